// *** cmt_defs.vh ***
// How it works
// - 16-bit up counter, interrupt on overflow
// - Counter read/write; resets zero and stopped
// - Count clock picks timebase divided output 0-6
// - Control register: clock select, run; reset 00
// - Unused control bits read zero; write zero
// - Two compare registers, reset zero, compared on each count step
// - Output control: two bits, upper six read one
// - Match outside PWM mode copies next level into output level
// - Match and interrupt only while counter runs
// - Toggle mode inverts next level after match
// - Mode register four bits, reset selects toggle
// - PWM: match A interrupts and sets flip-flop
// - Simultaneous set and clear: clear wins
// - PWM: pin A true, pin B complement
// - PWM: level bits do not affect outputs
// - Timebase divided outputs are the count source
`ifndef CMT_DEFS_VH
`define CMT_DEFS_VH
`define CMT_ADR_COUNT 4'h0
`define CMT_ADR_CTRL 4'h1
`define CMT_ADR_SEL 4'h2
`define CMT_ADR_CMPA 4'h3
`define CMT_ADR_CMPB 4'h4
`define CMT_ADR_OCA 4'h5
`define CMT_ADR_OCB 4'h6
`define CMT_ADR_MODE 4'h7
`define CMT_ADR_IRQ 4'h8
`define CMT_RST_SEL 16'h0300
`define CMT_RST_OC 8'h_fc
`define CMT_CTRL_MASK 8'h0f
`define CMT_CTRL_RUN 3
`define CMT_OC_OUT 0
`define CMT_OC_NEXT 1
`define CMT_MODE_RTO 2'h1
`define CMT_MODE_PWM 2'h2
`define CMT_MAX_SEL 3'h6
`define CMT_TB_PRE 4'h_f
`define CMT_IRQ_OVF 0
`define CMT_IRQ_A 1
`define CMT_IRQ_B 2
`define CMT_COUNT_MAX 16'hffff
`define CMT_OC_FILL 6'h3f
`endif

// *** cmt_timer.v ***
`timescale 1ns/100ps
`include "cmt_defs.vh"
module cmt_timer #(
	parameter [3:0] TB_DIV = `CMT_TB_PRE
) (
	input wire clk,
	input wire rst_n,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output reg avs_waitrequest,
	output reg realtime_pin_a,
	output reg realtime_pin_b,
	output reg irq_overflow,
	output reg irq_match_a,
	output reg irq_match_b
);
	reg [15:0] free_run_count_q;
	reg [7:0] counter_control_q;
	reg [15:0] counter_select_q;
	reg [15:0] compare_value_a_q;
	reg [15:0] compare_value_b_q;
	reg [1:0] output_control_a_q;
	reg [1:0] output_control_b_q;
	reg [3:0] compare_mode_select_q;
	reg [2:0] irq_flag_q;
	reg pwm_ff_q;
	reg [3:0] timebase_clock_cnt_q;
	reg [6:0] timebase_divider_q;
	reg [6:0] tb_prev_q;
	reg ack_q;
	reg [31:0] rd_d;
	reg tb_tick;
	reg cnt_tick;
	reg run;
	reg match_a;
	reg match_b;
	reg pwm_mode;
	wire access;
	wire wr_go;
	wire [7:0] wd8;
	wire wr_count;
	wire wr_ctrl;
	wire wr_sel;
	wire wr_cmpa;
	wire wr_cmpb;
	wire wr_oca;
	wire wr_ocb;
	wire wr_mode;
	wire wr_irq;
	wire overflow;
	wire [2:0] irq_event;
	wire [2:0] irq_clear;
	reg [7:0] ctrl_d;

	function [15:0] merge16;
		input [15:0] old;
		input [31:0] wd;
		input [3:0] be;
		begin
			merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
		end
	endfunction

	function [31:0] oc_read;
		input [1:0] bits;
		begin
			oc_read = {24'h0, `CMT_OC_FILL, bits};
		end
	endfunction

	assign access = (avs_read | avs_write) & ~ack_q;
	// Writes land only at the edge where the master sees waitrequest low
	assign wr_go = avs_write & ~avs_waitrequest;
	assign wd8 = avs_writedata[7:0];

	// Selected divided timebase edge enables counting
	always @* begin
		tb_tick = (timebase_clock_cnt_q == 4'h0);
		run = counter_control_q[`CMT_CTRL_RUN];
		if (counter_control_q[2:0] == 3'h0) begin
			cnt_tick = tb_tick;
		end else begin
			cnt_tick = timebase_divider_q[counter_control_q[2:0] - 3'h1]
				& ~tb_prev_q[counter_control_q[2:0] - 3'h1];
		end
		cnt_tick = cnt_tick & run;
		// Compare only while the counter runs and on its count step
		match_a = run && cnt_tick && (free_run_count_q == compare_value_a_q);
		match_b = run && cnt_tick && (free_run_count_q == compare_value_b_q);
		pwm_mode = (compare_mode_select_q[1:0] == `CMT_MODE_PWM);
	end

	always @* begin
		case (avs_address)
		`CMT_ADR_COUNT: rd_d = {16'h0, free_run_count_q};
		`CMT_ADR_CTRL: rd_d = {24'h0, counter_control_q & `CMT_CTRL_MASK};
		`CMT_ADR_SEL: rd_d = {16'h0, counter_select_q};
		`CMT_ADR_CMPA: rd_d = {16'h0, compare_value_a_q};
		`CMT_ADR_CMPB: rd_d = {16'h0, compare_value_b_q};
		`CMT_ADR_OCA: rd_d = oc_read(output_control_a_q);
		`CMT_ADR_OCB: rd_d = oc_read(output_control_b_q);
		`CMT_ADR_MODE: rd_d = {28'h0, compare_mode_select_q};
		`CMT_ADR_IRQ: rd_d = {29'h0, irq_flag_q};
		default: rd_d = 32'h0;
		endcase
	end

	// Timebase prescaler and 7-stage divider
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			timebase_clock_cnt_q <= 4'h0;
			timebase_divider_q <= 7'h0;
			tb_prev_q <= 7'h0;
		end else begin
			tb_prev_q <= timebase_divider_q;
			if (tb_tick) begin
				timebase_clock_cnt_q <= TB_DIV;
				timebase_divider_q <= timebase_divider_q + 7'h1;
			end else begin
				timebase_clock_cnt_q <= timebase_clock_cnt_q - 4'h1;
			end
		end
	end

	// Bus: one wait cycle, answer on second edge
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h0;
		end else begin
			ack_q <= access;
			avs_waitrequest <= ~access;
			if (access)
				avs_readdata <= rd_d;
		end
	end

	// One strobe per register
	assign wr_count = wr_go && (avs_address == `CMT_ADR_COUNT);
	assign wr_ctrl = wr_go && (avs_address == `CMT_ADR_CTRL) && avs_byteenable[0];
	assign wr_sel = wr_go && (avs_address == `CMT_ADR_SEL);
	assign wr_cmpa = wr_go && (avs_address == `CMT_ADR_CMPA);
	assign wr_cmpb = wr_go && (avs_address == `CMT_ADR_CMPB);
	assign wr_oca = wr_go && (avs_address == `CMT_ADR_OCA) && avs_byteenable[0];
	assign wr_ocb = wr_go && (avs_address == `CMT_ADR_OCB) && avs_byteenable[0];
	assign wr_mode = wr_go && (avs_address == `CMT_ADR_MODE) && avs_byteenable[0];
	assign wr_irq = wr_go && (avs_address == `CMT_ADR_IRQ) && avs_byteenable[0];

	assign overflow = cnt_tick && (free_run_count_q == `CMT_COUNT_MAX);
	assign irq_event = {match_b, match_a, overflow};
	assign irq_clear = wr_irq ? avs_writedata[2:0] : 3'h0;

	// Out-of-range clock selects clamp to the slowest tap
	always @* begin
		ctrl_d = wd8 & `CMT_CTRL_MASK;
		if (wd8[2:0] > `CMT_MAX_SEL) begin
			ctrl_d[2:0] = `CMT_MAX_SEL;
		end
	end

	// Free-running counter; a software write wins over a count step
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			free_run_count_q <= 16'h0;
		end else if (wr_count) begin
			free_run_count_q <= merge16(free_run_count_q, avs_writedata, avs_byteenable);
		end else if (cnt_tick) begin
			free_run_count_q <= free_run_count_q + 16'h1;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_control_q <= 8'h0;
		end else if (wr_ctrl) begin
			counter_control_q <= ctrl_d;
		end
	end

	// Kept only for software; it steers nothing in this block
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			counter_select_q <= `CMT_RST_SEL;
		end else if (wr_sel) begin
			counter_select_q <= merge16(counter_select_q, avs_writedata, avs_byteenable);
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_value_a_q <= 16'h0;
		end else if (wr_cmpa) begin
			compare_value_a_q <= merge16(compare_value_a_q, avs_writedata, avs_byteenable);
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_value_b_q <= 16'h0;
		end else if (wr_cmpb) begin
			compare_value_b_q <= merge16(compare_value_b_q, avs_writedata, avs_byteenable);
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			compare_mode_select_q <= 4'h0;
		end else if (wr_mode) begin
			compare_mode_select_q <= wd8[3:0];
		end
	end

	// Hardware match update takes precedence over a coincident write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			output_control_a_q <= 2'h0;
		end else if (match_a && !pwm_mode) begin
			output_control_a_q[`CMT_OC_OUT] <= output_control_a_q[`CMT_OC_NEXT];
			if (compare_mode_select_q[1:0] != `CMT_MODE_RTO) begin
				output_control_a_q[`CMT_OC_NEXT] <= ~output_control_a_q[`CMT_OC_NEXT];
			end
		end else if (wr_oca) begin
			output_control_a_q <= wd8[1:0];
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			output_control_b_q <= 2'h0;
		end else if (match_b && !pwm_mode) begin
			output_control_b_q[`CMT_OC_OUT] <= output_control_b_q[`CMT_OC_NEXT];
			if (compare_mode_select_q[3:2] != `CMT_MODE_RTO) begin
				output_control_b_q[`CMT_OC_NEXT] <= ~output_control_b_q[`CMT_OC_NEXT];
			end
		end else if (wr_ocb) begin
			output_control_b_q <= wd8[1:0];
		end
	end

	// Clear is tested first so that it wins a tie
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pwm_ff_q <= 1'b0;
		end else if (match_b && pwm_mode) begin
			pwm_ff_q <= 1'b0;
		end else if (match_a && pwm_mode) begin
			pwm_ff_q <= 1'b1;
		end
	end

	// Write-one-to-clear, but a new event wins
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_flag_q <= 3'h0;
		end else begin
			irq_flag_q <= (irq_flag_q & ~irq_clear) | irq_event;
		end
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_overflow <= 1'b0;
			irq_match_a <= 1'b0;
			irq_match_b <= 1'b0;
		end else begin
			irq_overflow <= irq_event[`CMT_IRQ_OVF];
			irq_match_a <= irq_event[`CMT_IRQ_A];
			irq_match_b <= irq_event[`CMT_IRQ_B];
		end
	end

	// Pins lag the level bits by one register stage
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			realtime_pin_a <= 1'b0;
			realtime_pin_b <= 1'b0;
		end else if (pwm_mode) begin
			realtime_pin_a <= pwm_ff_q;
			realtime_pin_b <= ~pwm_ff_q;
		end else begin
			realtime_pin_a <= output_control_a_q[`CMT_OC_OUT];
			realtime_pin_b <= output_control_b_q[`CMT_OC_OUT];
		end
	end
endmodule // cmt_timer

// *** cmt_checker.sv ***
`timescale 1ns/100ps
module cmt_checker (
	input wire clk,
	input wire rst_n,
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [31:0] avs_readdata,
	input wire avs_waitrequest,
	input wire realtime_pin_a,
	input wire realtime_pin_b,
	input wire irq_overflow,
	input wire irq_match_a,
	input wire irq_match_b
);
	reg run_q;
	reg [1:0] mode_q;
	wire wr_ok = avs_write && !avs_waitrequest;
	wire pwm = mode_q == 2'h2;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run_q <= 1'b0;
			mode_q <= 2'h0;
		end else if (wr_ok && avs_address == 4'h1) begin
			run_q <= avs_writedata[3];
		end else if (wr_ok && avs_address == 4'h7) begin
			mode_q <= avs_writedata[1:0];
		end
	end
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence
	a_ack_once: assert property (s_req |=> s_ack) else $error("ack");
	a_read_hold: assert property (!$stable(avs_readdata) |-> !avs_waitrequest) else $error("rd");
	a_ovf_pulse: assert property (irq_overflow |=> !irq_overflow) else $error("ovf");
	a_match_pulse: assert property (irq_match_a |=> !irq_match_a) else $error("irqa");
	// Four cycles cover the tick that lands on the stopping edge
	a_stop_quiet: assert property (!run_q && $past(!run_q, 4) |-> !(irq_overflow || irq_match_a)) else $error("stop");
	a_pwm_pair: assert property (pwm && $past(pwm, 4) |-> realtime_pin_b != realtime_pin_a) else $error("pair");
	a_pwm_set: assert property (pwm && irq_match_a && !irq_match_b |-> ##[0:3] realtime_pin_a) else $error("set");
	a_pwm_clear: assert property (pwm && irq_match_b |-> ##[0:3] !realtime_pin_a) else $error("clr");
endmodule // cmt_checker
bind cmt_timer cmt_checker i_chk (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
	.avs_writedata, .avs_readdata, .avs_waitrequest, .realtime_pin_a, .realtime_pin_b,
	.irq_overflow, .irq_match_a, .irq_match_b);

// *** cmt_pin_load.sv ***
`timescale 1ns/100ps
module cmt_pin_load (
	input wire clk,
	input wire pin_a,
	input wire pin_b,
	output reg [1:0] seen_q
);
	// External latch on push-pull pins, adds one cycle
	always @(posedge clk) begin
		seen_q <= {pin_b, pin_a};
	end
endmodule // cmt_pin_load

// *** cmt_tb.sv ***
`timescale 1ns/100ps
module testbench;
	reg clk = 1'b0;
	reg rst_n = 1'b0;
	reg [3:0] avs_address = 4'h0;
	reg avs_read = 1'b0;
	reg avs_write = 1'b0;
	reg [31:0] avs_writedata = 32'h0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire realtime_pin_a;
	wire realtime_pin_b;
	wire [2:0] irqs;
	wire [1:0] seen;
	int n_fail = 0;
	int checked = 0;
	int seed = 32'h6c15_f97c;
	int i;
	reg [31:0] rd;
	reg [15:0] va;
	reg [15:0] vb;
	cmt_timer #(.TB_DIV(4'h0)) i_dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hf), .avs_readdata, .avs_waitrequest,
		.realtime_pin_a, .realtime_pin_b, .irq_overflow(irqs[0]), .irq_match_a(irqs[1]),
		.irq_match_b(irqs[2]));
	cmt_pin_load i_load (.clk, .pin_a(realtime_pin_a), .pin_b(realtime_pin_b), .seen_q(seen));
	initial begin
		forever #25 clk = ~clk;
	end
	function logic [31:0] oc(input logic n, input logic o);
		return {24'h0, 6'h3f, n, o};
	endfunction
	function logic [31:0] rst_val(input int a);
		return a == 2 ? 32'h0300 : (a == 5 || a == 6) ? oc(1'b0, 1'b0) : 32'h0;
	endfunction
	task conclude;
		begin
			if (n_fail == 0 && checked > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		begin
			checked++;
			if (s !== e) begin
				n_fail++;
				$display("mismatch %0t %h %h", $time, s, e);
			end
		end
	endtask
	task bus(input logic we, input logic [3:0] a, input logic [31:0] d);
		int k;
		begin
			@(posedge clk);
			avs_address <= a;
			avs_writedata <= d;
			avs_write <= we;
			avs_read <= !we;
			for (k = 0; k < 20 && avs_waitrequest !== 1'b0; k++)
				@(posedge clk);
			chk(avs_waitrequest, 1'b0);
			if (avs_waitrequest !== 1'b0)
				conclude;
			rd = avs_readdata;
			avs_read <= 1'b0;
			avs_write <= 1'b0;
		end
	endtask
	task wirq(input int b);
		int k;
		begin
			for (k = 0; k < 300 && irqs[b] !== 1'b1; k++)
				@(posedge clk);
			chk(irqs[b], 1'b1);
			if (irqs[b] !== 1'b1)
				conclude;
			repeat (4) @(posedge clk);
		end
	endtask
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		for (i = 0; i < 10; i++) begin
			bus(1'b0, i[3:0], 32'h0);
			chk(rd, rst_val(i));
		end
		bus(1'b1, 4'h2, 32'h0300);
		bus(1'b1, 4'h1, 32'h00f7);
		bus(1'b0, 4'h1, 32'h0);
		chk(rd, 32'h0006);
		bus(1'b1, 4'h5, 32'h0002);
		bus(1'b0, 4'h5, 32'h0);
		chk(rd, oc(1'b1, 1'b0));
		va = 16'h0008 + ($random(seed) & 16'h001f);
		vb = va + 16'h0010 + ($random(seed) & 16'h001f);
		bus(1'b1, 4'h3, {16'h0, va});
		bus(1'b1, 4'h1, 32'h0008);
		wirq(1);
		chk(seen[0], 1'b1);
		bus(1'b0, 4'h5, 32'h0);
		chk(rd, oc(1'b0, 1'b1));
		bus(1'b1, 4'h0, 32'hfff8);
		wirq(0);
		bus(1'b1, 4'h1, 32'h0);
		bus(1'b1, 4'h7, 32'h0001);
		bus(1'b1, 4'h5, 32'h0001);
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h1, 32'h0008);
		wirq(1);
		chk(seen[0], 1'b0);
		bus(1'b0, 4'h5, 32'h0);
		chk(rd, oc(1'b0, 1'b0));
		bus(1'b1, 4'h1, 32'h0);
		bus(1'b1, 4'h7, 32'h0002);
		bus(1'b1, 4'h4, {16'h0, vb});
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h1, 32'h0008);
		wirq(1);
		chk(seen, 2'h1);
		bus(1'b1, 4'h5, 32'h0003);
		wirq(2);
		chk(seen, 2'h2);
		bus(1'b1, 4'h0, 32'h0);
		wirq(1);
		bus(1'b1, 4'h1, 32'h0);
		bus(1'b1, 4'h4, {16'h0, va});
		bus(1'b1, 4'h0, 32'h0);
		bus(1'b1, 4'h1, 32'h0008);
		wirq(2);
		chk(seen, 2'h2);
		conclude;
	end
endmodule // testbench
